// *** rtl/serial_lin_status_control_ext.sv ***
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module serial_lin_status_control_ext (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [1:0] wb_adr_i,
    input  wire logic [7:0] wb_dat_i,
    input  wire logic       wb_sel_i,
    output logic      [7:0] wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic       rxPin,
    input  wire logic       txPinIn,
    output logic            txPinOut,
    output logic            txPinOe,
    output logic            rxLine,
    input  wire logic       bitTick,
    input  wire logic       nineBitMode,
    input  wire logic       loopModeSelect,
    input  wire logic       receiverSourceSelect,
    input  wire logic       receiverStandby,
    input  wire logic       txSerialData,
    input  wire logic       txBreakRequest,
    output logic            txBreakActive,
    input  wire logic       rxLoad,
    input  wire logic       rxNinthIn,
    input  wire logic       rxFramingErrorIn,
    output logic            rxBufferFullSet,
    output logic            framingErrorSet,
    output logic            idleFlagSet,
    output logic            txNinthBit,
    input  wire logic       overrunFlag,
    input  wire logic       noiseFlag,
    input  wire logic       framingErrorFlag,
    input  wire logic       parityErrorFlag,
    output logic            errorIrq
);
    // bus: registered ack one cycle after the take,
    // so every access takes exactly one wait state
    // read data is zero outside the ack cycle
    // unmapped index or low select: acked, write dropped
    //
    // rx: three sync stages, a level is taken once
    // stages two and three agree; one-cycle glitches die
    // polarity is fixed after the filter, so edges
    // and counts see the corrected level
    //
    // break and idle lengths count bit ticks, so a
    // detection may land up to one bit time late
    //
    // tx: a break overrides the serial data and
    // ignores new requests until its count runs out
    //
    // the error request is a registered level
    //
    // the bus ack never depends on rx or tx state
    // so register access works in any mode

    // port groups:
    //   wb_*      register bus
    //   rxPin     receive pin, rxLine its corrected level
    //   txPin*    transmit pin drive and enable
    //   bitTick   one pulse per bit time
    //   modes     frame format and routing inputs
    //   rx*, tx*  handshakes with the shifters
    //   *Flag     error sources for errorIrq

    // status two: 7 break, 6 edge, 4 rx invert,
    //   3 idle report, 2 long break, 1 LIN detect,
    //   0 receiver active, 5 reads zero
    // control three: 7 rx ninth, 6 tx ninth,
    //   5 pin direction, 4 tx invert, 3..0 enables

    // limitations:
    //   txPinIn is unused; in single-wire mode the
    //   outer receiver takes the pin level itself
    //   the rx ninth bit is not captured while LIN
    //   detection masks the load
    //   low counts saturate at fifteen; harmless, the
    //   flag fires once per low stretch
    //   standby itself belongs to the main control
    //   the wake idle bit gates only the pulse

    // trade-offs:
    //   tick counting keeps counters at four bits,
    //   at up to one bit time of latency
    //   the registered read mux costs a cycle but
    //   keeps decode gates off the bus outputs
    //   one-hot tx states cost a flop, save decode


    // all state is one record: one comb block
    // builds the next record, one flop stage holds it
    // fields are grouped: bus, registers, rx, tx, out
    typedef struct packed {
        logic                       ack;
        logic [7:0]                 rdat;
        logic                       linBreakFlag;
        logic                       rxEdgeFlag;
        logic                       rxPolarityInvert;
        logic                       wakeIdleReport;
        logic                       longBreakSelect;
        logic                       linBreakDetectEnable;
        logic                       receiverActiveFlag;
        logic                       rxNinthBit;
        logic                       txNinthBit;
        logic                       singleWirePinDirection;
        logic                       txPolarityInvert;
        logic [3:0]                 irqEnable;
        logic [2:0]                 sync;
        logic                       rxLevel;
        logic [3:0]                 lowCount;
        logic                       breakSeen;
        logic [3:0]                 highCount;
        slsc_pkg::slsc_tx_state_type txState;
        logic                       breakActive;
        logic [3:0]                 txCount;
        logic                       txPin;
        logic                       txOe;
        logic                       rxOut;
        logic                       irq;
        logic                       idlePulse;
        logic                       framingPulse;
        logic                       fullPulse;
    } slsc_state_type;

    slsc_state_type state_q;
    slsc_state_type state_d;

    // helper terms
    logic       busRequest;
    logic       busWrite;
    logic       busRead;
    logic       hitStatus;
    logic       hitControl;
    logic       rawPrev;
    logic       rawNew;
    logic       dataPrev;
    logic       dataNew;
    logic       activeEdge;
    logic       singleWire;
    logic [3:0] frameLen;
    logic [3:0] breakThreshold;
    logic [3:0] breakTxLen;
    logic       breakDetected;
    logic       idleDetected;
    logic       clearLinBreak;
    logic       clearRxEdge;
    logic [3:0] errorFlags;

    // a take is blocked while ack is high
    always_comb begin
        busRequest = wb_cyc_i & wb_stb_i & ~state_q.ack;
        busWrite   = busRequest & wb_we_i & wb_sel_i;
        busRead    = busRequest & ~wb_we_i;
        hitStatus  = wb_adr_i == slsc_pkg::ADDR_STATUS_TWO;
        hitControl = wb_adr_i == slsc_pkg::ADDR_CONTROL_THREE;

        // only the filtered level is looked at, never the first sync stage
        rawPrev = state_q.rxLevel;
        rawNew  = (state_q.sync[1] == state_q.sync[2]) ? state_q.sync[2] : state_q.rxLevel;
        dataPrev = rawPrev ^ state_q.rxPolarityInvert;
        dataNew  = rawNew ^ state_q.rxPolarityInvert;
        activeEdge = state_q.rxPolarityInvert ? (~rawPrev & rawNew) : (rawPrev & ~rawNew);

        frameLen = slsc_pkg::FRAME_BITS + {3'h0, nineBitMode};
        breakThreshold = (state_q.linBreakDetectEnable ? slsc_pkg::BREAK_DETECT_LIN : slsc_pkg::BREAK_DETECT)
                         + {3'h0, nineBitMode};
        breakTxLen = (state_q.longBreakSelect ? slsc_pkg::BREAK_TX_LONG : slsc_pkg::BREAK_TX_SHORT)
                     + {3'h0, nineBitMode};

        breakDetected = bitTick & ~dataNew & ~state_q.breakSeen
                        & (state_q.lowCount + 4'h1 >= breakThreshold);
        idleDetected  = bitTick & dataNew & state_q.receiverActiveFlag
                        & (state_q.highCount + 4'h1 >= frameLen);

        clearLinBreak = busWrite & hitStatus & wb_dat_i[slsc_pkg::S2_LIN_BREAK_FLAG];
        clearRxEdge   = busWrite & hitStatus & wb_dat_i[slsc_pkg::S2_RX_EDGE_FLAG];

        singleWire = loopModeSelect & receiverSourceSelect;
        errorFlags = {overrunFlag, noiseFlag, framingErrorFlag, parityErrorFlag};
    end

    // next-state record; every field has a default
    always_comb begin
        state_d = state_q;

        state_d.ack  = busRequest;
        state_d.rdat = 8'h00;
        if (busRead && hitStatus) begin
            state_d.rdat[slsc_pkg::S2_LIN_BREAK_FLAG]   = state_q.linBreakFlag;
            state_d.rdat[slsc_pkg::S2_RX_EDGE_FLAG]     = state_q.rxEdgeFlag;
            state_d.rdat[slsc_pkg::S2_RX_INVERT]        = state_q.rxPolarityInvert;
            state_d.rdat[slsc_pkg::S2_WAKE_IDLE_REPORT] = state_q.wakeIdleReport;
            state_d.rdat[slsc_pkg::S2_LONG_BREAK]       = state_q.longBreakSelect;
            state_d.rdat[slsc_pkg::S2_LIN_DETECT_EN]    = state_q.linBreakDetectEnable;
            state_d.rdat[slsc_pkg::S2_RX_ACTIVE]        = state_q.receiverActiveFlag;
        end else if (busRead && hitControl) begin
            state_d.rdat[slsc_pkg::C3_RX_NINTH]  = state_q.rxNinthBit;
            state_d.rdat[slsc_pkg::C3_TX_NINTH]  = state_q.txNinthBit;
            state_d.rdat[slsc_pkg::C3_PIN_DIR]   = state_q.singleWirePinDirection;
            state_d.rdat[slsc_pkg::C3_TX_INVERT] = state_q.txPolarityInvert;
            state_d.rdat[3:0]                    = state_q.irqEnable;
        end

        if (busWrite && hitStatus) begin
            state_d.rxPolarityInvert     = wb_dat_i[slsc_pkg::S2_RX_INVERT];
            state_d.wakeIdleReport       = wb_dat_i[slsc_pkg::S2_WAKE_IDLE_REPORT];
            state_d.longBreakSelect      = wb_dat_i[slsc_pkg::S2_LONG_BREAK];
            state_d.linBreakDetectEnable = wb_dat_i[slsc_pkg::S2_LIN_DETECT_EN];
        end
        if (busWrite && hitControl) begin
            // ninth tx bit held until rewritten
            state_d.txNinthBit             = wb_dat_i[slsc_pkg::C3_TX_NINTH];
            state_d.singleWirePinDirection = wb_dat_i[slsc_pkg::C3_PIN_DIR];
            state_d.txPolarityInvert       = wb_dat_i[slsc_pkg::C3_TX_INVERT];
            state_d.irqEnable              = wb_dat_i[3:0];
        end

        // sync resets to ones: no false start
        // only stages two and three are compared
        // first stage feeds only the second
        state_d.sync    = {state_q.sync[1:0], rxPin};
        state_d.rxLevel = rawNew;
        state_d.rxOut   = dataNew;

        state_d.rxEdgeFlag = (state_q.rxEdgeFlag & ~clearRxEdge) | activeEdge;

        if (dataNew) begin
            state_d.lowCount  = 4'h0;
            state_d.breakSeen = 1'b0;
        end else if (bitTick && state_q.lowCount != 4'hF) begin
            state_d.lowCount = state_q.lowCount + 4'h1;
        end
        if (breakDetected) begin
            state_d.breakSeen = 1'b1;
        end
        // flag only with LIN detection on, set beats clear
        state_d.linBreakFlag = (state_q.linBreakFlag & ~clearLinBreak)
                               | (breakDetected & state_q.linBreakDetectEnable);

        if (!dataNew) begin
            state_d.highCount = 4'h0;
        end else if (bitTick && state_q.highCount != 4'hF) begin
            state_d.highCount = state_q.highCount + 4'h1;
        end
        // active from start edge until an idle line
        if (dataPrev && !dataNew) begin
            state_d.receiverActiveFlag = 1'b1;
        end else if (idleDetected) begin
            state_d.receiverActiveFlag = 1'b0;
        end
        // idle in standby reported only on request
        state_d.idlePulse = idleDetected & (~receiverStandby | state_q.wakeIdleReport);

        // side data is taken valid with the load
        // LIN detection masks framing and buffer full; long select plays no part
        state_d.framingPulse = rxLoad & rxFramingErrorIn & ~state_q.linBreakDetectEnable;
        state_d.fullPulse    = rxLoad & ~state_q.linBreakDetectEnable;
        // ninth rx bit captured with the byte
        if (rxLoad && !state_q.linBreakDetectEnable && nineBitMode) begin
            state_d.rxNinthBit = rxNinthIn;
        end

        // break count loads on the request and
        // counts down on ticks; mid-break requests
        // are not looked at

        case (state_q.txState)
            slsc_pkg::SLSC_TX_PASS: begin
                if (txBreakRequest) begin
                    state_d.txState = slsc_pkg::SLSC_TX_BREAK;
                    state_d.txCount = breakTxLen;
                end
            end
            slsc_pkg::SLSC_TX_BREAK: begin
                if (bitTick) begin
                    state_d.txCount = state_q.txCount - 4'h1;
                    if (state_q.txCount == 4'h1) begin
                        state_d.txState = slsc_pkg::SLSC_TX_PASS;
                    end
                end
            end
            default: begin
                state_d.txState = slsc_pkg::SLSC_TX_PASS;
                state_d.txCount = 4'h0;
            end
        endcase

        // next state drives the pin so it drops
        // on the edge the break begins
        // break is zero the whole character; whole line inverted
        state_d.txPin = ((state_d.txState == slsc_pkg::SLSC_TX_BREAK) ? 1'b0 : txSerialData)
                        ^ state_q.txPolarityInvert;
        // direction matters only in single-wire mode
        state_d.txOe = singleWire ? state_q.singleWirePinDirection : 1'b1;
        // own flop keeps the status output free of decode
        state_d.breakActive = state_d.txState == slsc_pkg::SLSC_TX_BREAK;

        // one cycle behind the flags
        // overrun; noise; framing; parity; merged
        state_d.irq = |(errorFlags & state_q.irqEnable);
    end

    // reset leaves lines idle high, pin driven
    // so nothing looks like a start bit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q         <= '0;
            state_q.sync    <= 3'h7;
            state_q.rxLevel <= 1'b1;
            state_q.rxOut   <= 1'b1;
            state_q.txPin   <= 1'b1;
            state_q.txOe    <= 1'b1;
            state_q.txState <= slsc_pkg::SLSC_TX_PASS;
        end else begin
            state_q <= state_d;
        end
    end

    // txPinIn is seen by the receive path of the outer logic in single-wire mode
    // plain register copies, no gates
    assign wb_dat_o        = state_q.rdat;
    assign wb_ack_o        = state_q.ack;
    assign txPinOut        = state_q.txPin;
    assign txPinOe         = state_q.txOe;
    assign rxLine          = state_q.rxOut;
    assign txBreakActive   = state_q.breakActive;
    assign rxBufferFullSet = state_q.fullPulse;
    assign framingErrorSet = state_q.framingPulse;
    assign idleFlagSet     = state_q.idlePulse;
    assign txNinthBit      = state_q.txNinthBit;
    assign errorIrq        = state_q.irq;

endmodule
`default_nettype wire

// *** rtl/slsc_pkg.sv ***
// Notes on behaviour
// - with LIN break detection on, a detected break sets bit 7; writing one clears it.
// - active rx edge sets bit 6 (falling, or rising when inverted); writing one clears.
// - rx invert bit 4 inverts the whole received line: data, start, stop, break, idle.
// - in wakeup standby an idle sets the idle flag only if bit 3 is one.
// - transmitted break lasts 10 bit times (11 nine-bit), or 13 (14) when long.
// - framing error detection ignores the long break select bit.
// - break detect threshold is 10 (11 nine-bit), or 11 (12) with LIN detection on.
// - with LIN break detection on, framing error and buffer full flags never set.
// - read-only bit 0 sets at a valid start bit and clears at an idle line.
// - in nine-bit mode bit 7 of control three holds the received ninth bit.
// - in nine-bit mode bit 6 is the ninth transmit bit and holds until rewritten.
// - in single-wire mode bit 5 makes the tx pin an output, else an input.
// - tx invert bit 4 inverts the whole transmitted line: data, start, stop, break, idle.
// - overrun flag with enable bit 3 requests an interrupt.
// - noise flag with enable bit 2 requests an interrupt.
// - framing error flag with enable bit 1 requests an interrupt.
// - parity error flag with enable bit 0 requests an interrupt.
// - nine-bit select gives nine data bits and a frame of 11 bits instead of 10.
// - a transmitted break holds logic zero for the whole character, start and stop too.
package slsc_pkg;

    localparam logic [1:0] ADDR_STATUS_TWO    = 2'h0;
    localparam logic [1:0] ADDR_CONTROL_THREE = 2'h1;

    // status two field positions
    localparam int S2_LIN_BREAK_FLAG   = 7;
    localparam int S2_RX_EDGE_FLAG     = 6;
    localparam int S2_RX_INVERT        = 4;
    localparam int S2_WAKE_IDLE_REPORT = 3;
    localparam int S2_LONG_BREAK       = 2;
    localparam int S2_LIN_DETECT_EN    = 1;
    localparam int S2_RX_ACTIVE        = 0;

    // control three field positions
    localparam int C3_RX_NINTH   = 7;
    localparam int C3_TX_NINTH   = 6;
    localparam int C3_PIN_DIR    = 5;
    localparam int C3_TX_INVERT  = 4;
    localparam int C3_OVERRUN_IE = 3;
    localparam int C3_NOISE_IE   = 2;
    localparam int C3_FRAMING_IE = 1;
    localparam int C3_PARITY_IE  = 0;

    localparam logic [7:0] STATUS_TWO_RESET    = 8'h00;
    localparam logic [7:0] CONTROL_THREE_RESET = 8'h00;

    // lengths in bit times
    localparam logic [3:0] FRAME_BITS       = 4'hA;
    localparam logic [3:0] BREAK_DETECT     = 4'hA;
    localparam logic [3:0] BREAK_DETECT_LIN = 4'hB;
    localparam logic [3:0] BREAK_TX_SHORT   = 4'hA;
    localparam logic [3:0] BREAK_TX_LONG    = 4'hD;

    typedef enum logic [1:0] {
        SLSC_TX_PASS  = 2'h1,
        SLSC_TX_BREAK = 2'h2
    } slsc_tx_state_type;

endpackage

// *** verif/slsc_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module slsc_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic rxLoad,
    input wire logic rxFramingErrorIn,
    input wire logic rxBufferFullSet,
    input wire logic framingErrorSet,
    input wire logic txBreakRequest,
    input wire logic txBreakActive,
    input wire logic txPinOut,
    input wire logic txPinOe,
    input wire logic loopModeSelect,
    input wire logic receiverSourceSelect,
    input wire logic overrunFlag,
    input wire logic noiseFlag,
    input wire logic framingErrorFlag,
    input wire logic parityErrorFlag,
    input wire logic errorIrq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus ack not a one cycle answer");
    property p_irq_quiet; !(overrunFlag || noiseFlag || framingErrorFlag || parityErrorFlag) |=> !errorIrq; endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq without any flag");
    property p_irq_cause; errorIrq |-> $past(overrunFlag || noiseFlag || framingErrorFlag || parityErrorFlag); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq has no cause");
    property p_full_cause; rxBufferFullSet |-> $past(rxLoad); endproperty
    a_full_cause: assert property (p_full_cause) else $error("buffer full pulse without load");
    property p_fe_cause; framingErrorSet |-> $past(rxLoad && rxFramingErrorIn); endproperty
    a_fe_cause: assert property (p_fe_cause) else $error("framing pulse without cause");
    property p_brk_start; $rose(txBreakActive) |-> $past(txBreakRequest); endproperty
    a_brk_start: assert property (p_brk_start) else $error("break began unasked");
    property p_brk_level; txBreakActive && $past(txBreakActive) |-> $stable(txPinOut); endproperty
    a_brk_level: assert property (p_brk_level) else $error("pin moved during break");
    property p_oe_dual; !(loopModeSelect && receiverSourceSelect) |=> txPinOe; endproperty
    a_oe_dual: assert property (p_oe_dual) else $error("pin not driven outside single wire");
endmodule
bind serial_lin_status_control_ext slsc_checker chk_u (.clock, .rstn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rxLoad,
    .rxFramingErrorIn, .rxBufferFullSet, .framingErrorSet, .txBreakRequest, .txBreakActive, .txPinOut, .txPinOe,
    .loopModeSelect, .receiverSourceSelect, .overrunFlag, .noiseFlag, .framingErrorFlag, .parityErrorFlag, .errorIrq);
`default_nettype wire

// *** verif/slsc_remote_node.sv ***
`timescale 1ns/1ns
`default_nettype none
module slsc_remote_node (
    input wire logic clock,
    input wire logic bitTick,
    input wire logic txPinOut,
    input wire logic txPinOe,
    output var logic rxPin,
    output logic     txPinIn
);
    // pull-up keeps the shared wire high while the pin is released
    assign txPinIn = txPinOe ? txPinOut : 1'b1;
    initial rxPin = 1'b1;
    // low stretch starts and ends on a bit boundary, so the tick count is exact
    task automatic lowFor(input int cnt);
        int k;
        k = 0;
        @(posedge clock iff bitTick);
        rxPin <= 1'b0;
        while (k < cnt) begin
            @(posedge clock);
            if (bitTick) k++;
        end
        rxPin <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_sel_i = 1'b0, bitTick = 1'b0;
    logic [1:0]  wb_adr_i = 2'h0;
    logic [7:0]  wb_dat_i = 8'h00;
    logic        nineBitMode = 1'b0, loopModeSelect = 1'b0, receiverSourceSelect = 1'b0, receiverStandby = 1'b0;
    logic        txSerialData = 1'b1, txBreakRequest = 1'b0, rxLoad = 1'b0, rxNinthIn = 1'b0, rxFramingErrorIn = 1'b0;
    logic        overrunFlag = 1'b0, noiseFlag = 1'b0, framingErrorFlag = 1'b0, parityErrorFlag = 1'b0;
    logic [2:0]  tickDiv = 3'h0;
    logic [31:0] seed = 32'h6078;
    wire logic [7:0] wb_dat_o;
    wire logic   wb_ack_o, rxPin, txPinIn, txPinOut, txPinOe, rxLine, txBreakActive, rxBufferFullSet;
    wire logic   framingErrorSet, idleFlagSet, txNinthBit, errorIrq;
    int          num_errors = 0, check_count = 0, n, t;
    always #10 clock = ~clock;
    always @(posedge clock) begin
        tickDiv <= tickDiv + 3'h1;
        bitTick <= (tickDiv == 3'h7);
    end
    serial_lin_status_control_ext dut_u (.clock, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_dat_o, .wb_ack_o, .rxPin, .txPinIn, .txPinOut, .txPinOe, .rxLine, .bitTick, .nineBitMode,
        .loopModeSelect, .receiverSourceSelect, .receiverStandby, .txSerialData, .txBreakRequest, .txBreakActive,
        .rxLoad, .rxNinthIn, .rxFramingErrorIn, .rxBufferFullSet, .framingErrorSet, .idleFlagSet, .txNinthBit,
        .overrunFlag, .noiseFlag, .framingErrorFlag, .parityErrorFlag, .errorIrq);
    slsc_remote_node node_u (.clock, .bitTick, .txPinOut, .txPinOe, .rxPin, .txPinIn);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [7:0] brkLen(input logic longBrk, input logic nine);
        return (longBrk ? 8'h0D : 8'h0A) + {7'h00, nine};
    endfunction
    task give_verdict;
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read data is compared only on reads
    task automatic acc(input logic we, input logic [1:0] a, input logic [7:0] d, input logic s, input logic [7:0] e);
        int w;
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, s};
        for (w = 0; w < 50; w++) begin
            @(posedge clock);
            if (wb_ack_o === 1'b1) break;
        end
        if (w == 50) begin
            num_errors++;
            give_verdict();
        end
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (!we) chk(wb_dat_o, e);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        acc(1'b0, 2'h0, 8'h00, 1'b1, slsc_pkg::STATUS_TWO_RESET);
        acc(1'b0, 2'h1, 8'h00, 1'b1, slsc_pkg::CONTROL_THREE_RESET);
        acc(1'b1, 2'h2, 8'hFF, 1'b1, 8'h00);
        acc(1'b0, 2'h2, 8'h00, 1'b1, 8'h00);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            acc(1'b1, 2'h1, seed[7:0], 1'b1, 8'h00);
            acc(1'b0, 2'h1, 8'h00, 1'b1, seed[7:0] & 8'h7F);
            chk(txNinthBit, seed[6]);
        end
        acc(1'b1, 2'h1, ~seed[7:0], 1'b0, 8'h00);
        acc(1'b0, 2'h1, 8'h00, 1'b1, seed[7:0] & 8'h7F);
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 2'h1, 8'h0F, 1'b1, 8'h00);
            {overrunFlag, noiseFlag, framingErrorFlag, parityErrorFlag} <= 4'h8 >> k;
            repeat (3) @(posedge clock);
            chk(errorIrq, 8'h01);
            acc(1'b1, 2'h1, 8'h0F ^ (8'h08 >> k), 1'b1, 8'h00);
            repeat (3) @(posedge clock);
            chk(errorIrq, 8'h00);
        end
        {overrunFlag, noiseFlag, framingErrorFlag, parityErrorFlag} <= 4'h0;
        for (int k = 0; k < 4; k++) begin
            nineBitMode <= k[0];
            acc(1'b1, 2'h0, k[1] ? 8'h04 : 8'h00, 1'b1, 8'h00);
            acc(1'b1, 2'h1, k[0] ? 8'h10 : 8'h00, 1'b1, 8'h00);
            txBreakRequest <= 1'b1;
            @(posedge clock);
            txBreakRequest <= 1'b0;
            n = 0;
            for (t = 0; t < 400 && (t < 2 || txBreakActive === 1'b1); t++) begin
                @(posedge clock);
                if (t == 3) chk(txPinOut, k[0]);
                if (bitTick && txBreakActive === 1'b1) n++;
            end
            chk(n[7:0], brkLen(k[1], k[0]));
            chk(txPinOut, !k[0]);
        end
        {loopModeSelect, receiverSourceSelect} <= 2'h3;
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, 2'h1, k ? 8'h20 : 8'h00, 1'b1, 8'h00);
            repeat (2) @(posedge clock);
            chk(txPinOe, k[7:0]);
        end
        {loopModeSelect, receiverSourceSelect, nineBitMode} <= 3'h0;
        for (int k = 9; k < 12; k++) begin
            acc(1'b1, 2'h0, k == 9 ? 8'h00 : 8'h02, 1'b1, 8'h00);
            node_u.lowFor(k == 9 ? 12 : k);
            repeat (8) @(posedge clock);
            acc(1'b0, 2'h0, 8'h00, 1'b1, k == 11 ? 8'hC3 : (k == 9 ? 8'h41 : 8'h43));
            acc(1'b1, 2'h0, k == 9 ? 8'h40 : 8'hC2, 1'b1, 8'h00);
            repeat (110) @(posedge clock);
            acc(1'b0, 2'h0, 8'h00, 1'b1, k == 9 ? 8'h00 : 8'h02);
        end
        acc(1'b1, 2'h0, 8'h10, 1'b1, 8'h00);
        repeat (3) @(posedge clock);
        chk(rxLine, 8'h00);
        node_u.lowFor(1);
        repeat (8) @(posedge clock);
        acc(1'b0, 2'h0, 8'h00, 1'b1, 8'h51);
        for (int k = 0; k < 3; k++) begin
            receiverStandby <= k > 0;
            acc(1'b1, 2'h0, k == 2 ? 8'h48 : 8'h40, 1'b1, 8'h00);
            if (k > 0) node_u.lowFor(1);
            n = 0;
            repeat (130) @(posedge clock) if (idleFlagSet === 1'b1) n++;
            chk(n[7:0], k == 1 ? 8'h00 : 8'h01);
        end
        receiverStandby <= 1'b0;
        acc(1'b1, 2'h1, 8'h00, 1'b1, 8'h00);
        {nineBitMode, rxFramingErrorIn} <= 2'h3;
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 2'h0, {5'h00, k[1], k[0], 1'b0}, 1'b1, 8'h00);
            {rxNinthIn, rxLoad} <= {k == 1 || k == 2, 1'b1};
            @(posedge clock);
            rxLoad <= 1'b0;
            #1;
            chk(rxBufferFullSet, !k[0]);
            chk(framingErrorSet, !k[0]);
            acc(1'b0, 2'h1, 8'h00, 1'b1, {k[1], 7'h00});
        end
        give_verdict();
    end
endmodule
`default_nettype wire
